/* File: verilog/brd_pkg.sv */
// Shared constants for the board status/control register bank and its host controller
package brd_pkg;
	// Device register map on the link
	localparam logic [15:0] BRD_STATUS_ADDR = 16'h8200;
	localparam logic [15:0] BRD_CTRL_ADDR = 16'h8201;
	localparam logic [15:0] BRD_OPTID_ADDR = 16'h8204;
	localparam logic [7:0] BRD_HW_RESET_KEY = 8'hA5;
	localparam logic [7:0] BRD_UNMAPPED_RD = 8'h00;
	// Status register bit positions
	localparam int BRD_ST_ATT_IRQ = 0;
	localparam int BRD_ST_ERR_IRQ = 1;
	localparam int BRD_ST_ATT_POLL = 2;
	localparam int BRD_ST_ERR_POLL = 3;
	localparam int BRD_ST_WD = 4;
	localparam int BRD_ST_FIXED5 = 5;
	localparam int BRD_ST_BAT = 6;
	localparam int BRD_ST_TEMP = 7;
	// Control register bit positions
	localparam int BRD_CT_ATT_EN = 0;
	localparam int BRD_CT_ERR_EN = 1;
	localparam int BRD_CT_FREEZE = 2;
	localparam int BRD_CT_SRC = 3;
	localparam int BRD_CT_USER = 4;
	localparam int BRD_CT_ACTION = 5;
	localparam int BRD_CT_KICK = 6;
	localparam int BRD_CT_TRIG = 7;
	// Control register reset image and fixed readback bits
	localparam logic [7:0] BRD_CTRL_RESET = 8'h05;
	localparam logic BRD_ERR_EN_N_VAL = 1'b0;
	localparam logic BRD_UNUSED_VAL = 1'b1;
	localparam logic BRD_SRC_VAL = 1'b1;
	localparam logic BRD_TRIG_VAL = 1'b1;
	// Host controller APB register offsets
	localparam logic [7:0] BRD_H_ADDR = 8'h00;
	localparam logic [7:0] BRD_H_WDATA = 8'h04;
	localparam logic [7:0] BRD_H_CMD = 8'h08;
	localparam logic [7:0] BRD_H_RDATA = 8'h0C;
	localparam logic [7:0] BRD_H_IRQ_ST = 8'h10;
	localparam logic [7:0] BRD_H_IRQ_MASK = 8'h14;
	// Host command and interrupt register fields
	localparam int BRD_CMD_GO = 0;
	localparam int BRD_CMD_WRITE = 1;
	localparam int BRD_CMD_BUSY = 0;
	localparam int BRD_IRQ_DONE = 0;
	// Host transfer states
	typedef enum logic [1:0] {
		BRD_H_IDLE = 2'b00,
		BRD_H_REQ = 2'b01
	} brd_host_state_t;
endpackage

/* File: verilog/brd_link_if.sv */
// I/O port link between the host controller and the board register bank
`timescale 1ns/1ps
interface brd_link_if;
	logic req;
	logic we;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	modport device (
		input req,
		input we,
		input addr,
		input wdata,
		output rdata,
		output ack
	);
	modport host (
		output req,
		output we,
		output addr,
		output wdata,
		input rdata,
		input ack
	);
endinterface

/* File: verilog/brd_sync2.sv */
// Two flip-flop synchroniser for board pin levels
`timescale 1ns/1ps
module brd_sync2 #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Asynchronous levels in, synchronised out
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule // brd_sync2

/* File: verilog/brd_device.sv */
// Board status and control register bank, device end of the link
//
// Local design decision: the link register port to the host.
`timescale 1ns/1ps
module brd_device
	import brd_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Link to host
	brd_link_if.device link,
	// Board pins, asynchronous, active low
	input wire logic chan_check_n_i,
	input wire logic battery_low_n_i,
	input wire logic temp_limit_n_i,
	// Watchdog counter expiry, one-cycle pulse on this clock
	input wire logic wd_expired_i,
	// Board outputs
	output logic user_out_n_o,
	output logic trigger_n_o,
	output logic wd_kick_o,
	output logic hw_reset_o
);
	// Address match shared by every register decode
	function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
		addr_hit = (a == off);
	endfunction

	// Synchronised pin levels
	logic [2:0] pins_s;
	logic error_irq_pending_n;
	logic battery_low_flag_n;
	logic temp_limit_flag_n;

	// Link decode
	logic ack_r;
	logic take;
	logic wr_take;
	logic rd_take;
	logic hit_status;
	logic hit_ctrl;
	logic hit_optid;
	logic ctrl_wr;
	logic reset_key;

	// Control state
	logic wd_kick_bit_r;
	logic wd_kick_bit_nxt;
	logic wd_action_select_r;
	logic wd_action_select_nxt;
	logic user_out_r;
	logic user_out_nxt;
	logic kick_change;

	// Watchdog timeout latch
	logic wd_timed_out_n_r;
	logic wd_timed_out_n_nxt;
	logic wd_reset_req;

	// Readback
	logic [7:0] status_val;
	logic [7:0] ctrl_val;
	logic [7:0] rd_val;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// Output flops
	logic user_out_n_r;
	logic trigger_n_r;
	logic trigger_n_nxt;
	logic wd_kick_r;
	logic hw_reset_r;

	brd_sync2 #(
		.WIDTH(3),
		.RST_VAL(3'h7)
	) u_pin_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.d_i({temp_limit_n_i, battery_low_n_i, chan_check_n_i}),
		.q_o(pins_s)
	);

	assign error_irq_pending_n = pins_s[0];
	assign battery_low_flag_n = pins_s[1];
	assign temp_limit_flag_n = pins_s[2];

	// Ack flop blocks a second take while the host still holds req
	assign take = link.req && !ack_r;
	assign wr_take = take && link.we;
	assign rd_take = take && !link.we;
	assign hit_status = addr_hit(link.addr, BRD_STATUS_ADDR);
	assign hit_ctrl = addr_hit(link.addr, BRD_CTRL_ADDR);
	assign hit_optid = addr_hit(link.addr, BRD_OPTID_ADDR);
	// Status writes are decoded as nothing; reserved bits have no effect
	assign ctrl_wr = wr_take && hit_ctrl;
	assign reset_key = wr_take && hit_optid && (link.wdata == BRD_HW_RESET_KEY);

	// Only D4, D5 and D6 are stored; the rest are fixed
	assign wd_kick_bit_nxt = ctrl_wr ? link.wdata[BRD_CT_KICK] : wd_kick_bit_r;
	assign wd_action_select_nxt = ctrl_wr ? link.wdata[BRD_CT_ACTION] : wd_action_select_r;
	assign user_out_nxt = ctrl_wr ? link.wdata[BRD_CT_USER] : user_out_r;
	assign kick_change = ctrl_wr && (link.wdata[BRD_CT_KICK] != wd_kick_bit_r);

	// Timeout beats a simultaneous reset key so the event is not lost
	assign wd_timed_out_n_nxt = wd_expired_i ? 1'b0 :
		(reset_key ? 1'b1 : wd_timed_out_n_r);
	// Action select 1 is unsupported: the timeout is then only latched
	assign wd_reset_req = reset_key || (wd_expired_i && !wd_action_select_r);

	// Unused flags read high so polled software never sees an event
	assign status_val = {
		temp_limit_flag_n,
		battery_low_flag_n,
		BRD_UNUSED_VAL,
		wd_timed_out_n_r,
		BRD_UNUSED_VAL,
		BRD_UNUSED_VAL,
		error_irq_pending_n,
		BRD_UNUSED_VAL
	};

	// Fixed control bits cost no flops and ignore writes
	assign ctrl_val = {
		BRD_TRIG_VAL,
		wd_kick_bit_r,
		wd_action_select_r,
		user_out_r,
		BRD_SRC_VAL,
		BRD_UNUSED_VAL,
		BRD_ERR_EN_N_VAL,
		BRD_UNUSED_VAL
	};

	assign rd_val = hit_status ? status_val :
		(hit_ctrl ? ctrl_val : BRD_UNMAPPED_RD);
	assign rdata_nxt = rd_take ? rd_val : rdata_r;

	// Source select fixed at 1, so the direct bit owns the pin
	// Timer and clock sources are not modelled; the pin idles high then
	assign trigger_n_nxt = ctrl_val[BRD_CT_SRC] ? ctrl_val[BRD_CT_TRIG] : 1'b1;

	// Ack and read data are registers so the host sees clean levels
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ack_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			ack_r <= take;
			rdata_r <= rdata_nxt;
		end
	end

	// Stored control bits start from the reset image
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wd_kick_bit_r <= BRD_CTRL_RESET[BRD_CT_KICK];
			wd_action_select_r <= BRD_CTRL_RESET[BRD_CT_ACTION];
			user_out_r <= BRD_CTRL_RESET[BRD_CT_USER];
		end else begin
			wd_kick_bit_r <= wd_kick_bit_nxt;
			wd_action_select_r <= wd_action_select_nxt;
			user_out_r <= user_out_nxt;
		end
	end

	// Power-on reset clears the latch as well as the reset key
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wd_timed_out_n_r <= 1'b1;
		end else begin
			wd_timed_out_n_r <= wd_timed_out_n_nxt;
		end
	end

	// Outputs are flopped so the pins never glitch on decode
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			user_out_n_r <= 1'b1;
			trigger_n_r <= 1'b1;
			wd_kick_r <= 1'b0;
			hw_reset_r <= 1'b0;
		end else begin
			user_out_n_r <= ~user_out_nxt;
			trigger_n_r <= trigger_n_nxt;
			wd_kick_r <= kick_change;
			hw_reset_r <= wd_reset_req;
		end
	end

	// Read data stands from the take edge until the next read take
	assign link.ack = ack_r;
	assign link.rdata = rdata_r;
	assign user_out_n_o = user_out_n_r;
	assign trigger_n_o = trigger_n_r;
	assign wd_kick_o = wd_kick_r;
	assign hw_reset_o = hw_reset_r;
endmodule // brd_device

/* File: verilog/brd_host.sv */
// Host controller: APB command registers driving the board link
`timescale 1ns/1ps
module brd_host
	import brd_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Interrupt
	output logic irq_o,
	// Link to board
	brd_link_if.host link
);
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		is_reg = (a == off);
	endfunction

	brd_host_state_t state_r;
	brd_host_state_t state_nxt;
	logic [15:0] addr_r;
	logic [7:0] wdata_r;
	logic we_r;
	logic [7:0] rdata_r;
	logic done_st_r;
	logic done_mask_r;
	logic [31:0] prdata_r;
	logic setup;
	logic acc_wr;
	logic acc_rd;
	logic go;
	logic done_evt;
	logic st_clr;
	logic [31:0] rd_mux;

	assign setup = psel_i && !penable_i;
	assign acc_wr = psel_i && penable_i && pwrite_i;
	assign acc_rd = psel_i && penable_i && !pwrite_i;
	// Start while busy is ignored
	assign go = acc_wr && is_reg(paddr_i, BRD_H_CMD) && pwdata_i[BRD_CMD_GO]
		&& (state_r == BRD_H_IDLE);
	assign done_evt = (state_r == BRD_H_REQ) && link.ack;
	// Clear only what the read returned, so a new event wins
	assign st_clr = acc_rd && is_reg(paddr_i, BRD_H_IRQ_ST) && prdata_r[BRD_IRQ_DONE];

	assign rd_mux = is_reg(paddr_i, BRD_H_ADDR) ? {16'h0000, addr_r} :
		is_reg(paddr_i, BRD_H_WDATA) ? {24'h000000, wdata_r} :
		is_reg(paddr_i, BRD_H_CMD) ? {31'h00000000, state_r == BRD_H_REQ} :
		is_reg(paddr_i, BRD_H_RDATA) ? {24'h000000, rdata_r} :
		is_reg(paddr_i, BRD_H_IRQ_ST) ? {31'h00000000, done_st_r} :
		is_reg(paddr_i, BRD_H_IRQ_MASK) ? {31'h00000000, done_mask_r} :
		32'h00000000;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			BRD_H_IDLE: begin
				if (go) begin
					state_nxt = BRD_H_REQ;
				end
			end
			BRD_H_REQ: begin
				if (link.ack) begin
					state_nxt = BRD_H_IDLE;
				end
			end
			default: begin
				state_nxt = BRD_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_r <= BRD_H_IDLE;
			we_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (go) begin
				we_r <= pwdata_i[BRD_CMD_WRITE];
			end
			if (done_evt && !we_r) begin
				rdata_r <= link.rdata;
			end
		end
	end

	// Address and data are only written while idle, so req sees them stable
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
			done_mask_r <= 1'b0;
		end else begin
			if (acc_wr && is_reg(paddr_i, BRD_H_ADDR) && state_r == BRD_H_IDLE) begin
				addr_r <= pwdata_i[15:0];
			end
			if (acc_wr && is_reg(paddr_i, BRD_H_WDATA) && state_r == BRD_H_IDLE) begin
				wdata_r <= pwdata_i[7:0];
			end
			if (acc_wr && is_reg(paddr_i, BRD_H_IRQ_MASK)) begin
				done_mask_r <= pwdata_i[BRD_IRQ_DONE];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			done_st_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			done_st_r <= done_evt || (done_st_r && !st_clr);
			if (setup) begin
				prdata_r <= rd_mux;
			end
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	assign irq_o = done_st_r && done_mask_r;
	assign link.req = (state_r == BRD_H_REQ);
	assign link.we = we_r;
	assign link.addr = addr_r;
	assign link.wdata = wdata_r;
endmodule // brd_host

/* File: sim/brd_link_props.sv */
// Link protocol checks between the host controller and the board register bank
`timescale 1ns/1ps
module brd_link_props
	import brd_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Link signals
	input wire logic req,
	input wire logic we,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	wire rd_ack = ack && !we;
	chk_ack_one_cycle: assert property (ack |=> !ack)
		else $error("ack held longer than one cycle");
	chk_ack_after_req: assert property ($rose(req) |=> ack)
		else $error("no ack one cycle after request");
	chk_ack_has_req: assert property (ack |-> $past(req))
		else $error("ack without a request");
	chk_req_drop: assert property (ack |=> !req)
		else $error("request not dropped after ack");
	chk_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
		&& $stable(wdata)) else $error("request changed before ack");
	chk_status_fixed: assert property (
		rd_ack && addr == BRD_STATUS_ADDR |-> rdata[5] && rdata[3:2] == 2'b11 && rdata[0])
		else $error("status fixed bits wrong");
	chk_ctrl_fixed: assert property (
		rd_ack && addr == BRD_CTRL_ADDR |-> (rdata & 8'h8F) == 8'h8D)
		else $error("control fixed bits wrong");
	chk_unmapped_zero: assert property (
		rd_ack && addr[15:8] != 8'h82 |-> rdata == BRD_UNMAPPED_RD)
		else $error("unmapped read not zero");
endmodule // brd_link_props

/* File: sim/testbench.sv */
// Self-checking bench joining the host controller and the board register bank
`timescale 1ns/1ps
module testbench
	import brd_pkg::*;
;
	logic clk, rst_n, psel, penable, pwrite, chan_n, bat_n, temp_n, wd_exp, msk, prev6;
	logic [7:0] paddr, wv;
	logic [31:0] pwdata, prdata, q, r;
	logic pready, pslverr, irq, user_n, trig_n, kick, hw_rst;
	logic [31:0] seed = 32'h11;
	int err_count, checked, kicks, resets, base;
	brd_link_if lnk();
	brd_host brd_host_inst (.clock_i(clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
		.link(lnk.host));
	brd_device brd_device_inst (.clock_i(clk), .rst_n_i(rst_n), .link(lnk.device),
		.chan_check_n_i(chan_n), .battery_low_n_i(bat_n), .temp_limit_n_i(temp_n),
		.wd_expired_i(wd_exp), .user_out_n_o(user_n), .trigger_n_o(trig_n),
		.wd_kick_o(kick), .hw_reset_o(hw_rst));
	brd_link_props brd_link_props_inst (.clock_i(clk), .rst_n_i(rst_n), .req(lnk.req),
		.we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		kicks += int'(kick === 1'b1);
		resets += int'(hw_rst === 1'b1);
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_st(input logic wd);
		return {temp_n, bat_n, 1'b1, wd, 2'b11, chan_n, 1'b1};
	endfunction
	function automatic logic [7:0] exp_ct(input logic [7:0] w);
		return {1'b1, w[6:4], 4'hD};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_count++;
			conclude();
		end
		q = prdata;
		chk({7'h00, pslverr}, 8'h00);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Full link transfer; also checks the done interrupt and its read-clear
	task automatic dev_op(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		apb(1'b1, BRD_H_ADDR, {16'h0000, a});
		apb(1'b1, BRD_H_WDATA, {24'h000000, d});
		apb(1'b1, BRD_H_CMD, {30'h00000000, w, 1'b1});
		n = 0;
		do begin
			apb(1'b0, BRD_H_CMD, 32'h00000000);
			n++;
		end while (q[BRD_CMD_BUSY] !== 1'b0 && n < 16);
		if (n >= 16) begin
			err_count++;
			conclude();
		end
		chk({7'h00, irq}, {7'h00, msk});
		apb(1'b0, BRD_H_IRQ_ST, 32'h00000000);
		chk({7'h00, q[BRD_IRQ_DONE]}, 8'h01);
		chk({7'h00, irq}, 8'h00);
		apb(1'b0, BRD_H_RDATA, 32'h00000000);
	endtask
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{chan_n, bat_n, temp_n, wd_exp, msk, prev6} = 6'b111010;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({7'h00, user_n}, 8'h01);
		chk({7'h00, trig_n}, 8'h01);
		apb(1'b1, BRD_H_IRQ_MASK, 32'h00000001);
		dev_op(1'b0, BRD_CTRL_ADDR, 8'h00);
		chk(q[7:0], exp_ct(BRD_CTRL_RESET));
		// Pins pass a two-flop synchroniser, so settle before reading
		for (int i = 0; i < 7; i++) begin
			r = (i == 0) ? 32'h00000000 : xs();
			{chan_n, bat_n, temp_n} <= r[2:0];
			repeat (4) @(posedge clk);
			dev_op(1'b0, BRD_STATUS_ADDR, 8'h00);
			chk(q[7:0], exp_st(1'b1));
		end
		dev_op(1'b1, BRD_STATUS_ADDR, 8'h00);
		dev_op(1'b0, BRD_STATUS_ADDR, 8'h00);
		chk(q[7:0], exp_st(1'b1));
		for (int i = 0; i < 10; i++) begin
			r = xs();
			wv = (r[7:0] | 8'h08) & 8'hDF;
			if (i < 2)
				wv = (i == 0) ? 8'hDF : 8'h08;
			msk = r[8];
			apb(1'b1, BRD_H_IRQ_MASK, {31'h00000000, r[8]});
			base = kicks;
			dev_op(1'b1, BRD_CTRL_ADDR, wv);
			chk(8'(kicks - base), {7'h00, wv[6] != prev6});
			prev6 = wv[6];
			chk({7'h00, user_n}, {7'h00, !wv[4]});
			chk({7'h00, trig_n}, 8'h01);
			dev_op(1'b0, BRD_CTRL_ADDR, 8'h00);
			chk(q[7:0], exp_ct(wv));
		end
		base = resets;
		wd_exp <= 1'b1;
		@(posedge clk);
		wd_exp <= 1'b0;
		dev_op(1'b0, BRD_STATUS_ADDR, 8'h00);
		chk(8'(resets - base), 8'h01);
		chk(q[7:0], exp_st(1'b0));
		// A wrong key must leave the latch alone
		dev_op(1'b1, BRD_OPTID_ADDR, 8'h5A);
		dev_op(1'b0, BRD_STATUS_ADDR, 8'h00);
		chk(q[7:0], exp_st(1'b0));
		chk(8'(resets - base), 8'h01);
		dev_op(1'b1, BRD_OPTID_ADDR, BRD_HW_RESET_KEY);
		dev_op(1'b0, BRD_STATUS_ADDR, 8'h00);
		chk(q[7:0], exp_st(1'b1));
		chk(8'(resets - base), 8'h02);
		dev_op(1'b0, 16'h0300, 8'h00);
		chk(q[7:0], BRD_UNMAPPED_RD);
		apb(1'b0, 8'h1C, 32'h00000000);
		chk(q[7:0], 8'h00);
		conclude();
	end
	initial begin
		repeat (50000) @(posedge clk);
		err_count++;
		conclude();
	end
endmodule // testbench
